// File: acsr_pkg.sv
/*
 * acsr_pkg: register map, field positions, reset values and timing counts
 * for the converter control, status and result block.
 * assumes: byte-wide register port at printed data-space offsets.
 */
package acsr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RESULT_LOW = 8'h78;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h79;
    localparam logic [7:0] OFF_CONTROL_STATUS = 8'h7A;
    localparam logic [7:0] OFF_TRIGGER_CONTROL = 8'h7B;
    localparam logic [7:0] OFF_INPUT_SELECT = 8'h7C;
    localparam logic [7:0] OFF_PIN_DISABLE = 8'h7E;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h81;
    // ------------------------------------------------------------
    // control/status fields
    // ------------------------------------------------------------
    localparam int BIT_CONVERTER_ON = 7;
    localparam int BIT_START_BUSY = 6;
    localparam int BIT_AUTO_TRIG_EN = 5;
    localparam int BIT_DONE_FLAG = 4;
    localparam int BIT_DONE_IRQ_EN = 3;
    localparam int BIT_LEFT_ALIGN = 5;
    localparam logic [7:0] TRIG_CTRL_WMASK = 8'h47;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
    localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
    localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
    // irq status bits: 0 conversion done, 1 result overrun while locked
    localparam int IRQ_BITS = 2;
endpackage : acsr_pkg

// File: acsr_ctrl.sv
/*
 * acsr_ctrl: control, status and result logic of a 10-bit converter.
 * holds the prescaler, conversion sequencer, result lock and alignment,
 * auto-trigger selection, pin input disable and interrupt gathering.
 * assumes: the analog core supplies a 10-bit sample whenever a conversion
 * ends; trigger flags and pin levels come from outside this clock domain.
 */
`timescale 1ns/10ps

module acsr_ctrl
    import acsr_pkg::*;
#(
    parameter int RESULT_W = 10,
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // cpu interrupt handshake
    input wire logic global_irq_en_in,
    input wire logic vector_taken_in,
    output logic conv_irq_req_out,
    output logic irq_out,
    // analog core
    input wire logic [RESULT_W-1:0] sample_in,
    output logic core_power_out,
    output logic core_clk_en_out,
    output logic [4:0] input_select_out,
    output logic [1:0] ref_select_out,
    // trigger flags, index 1..7 used
    input wire logic [7:1] trig_flags_in,
    // analog pins
    input wire logic [PINS-1:0] pin_level_in,
    output logic [PINS-1:0] pin_read_out,
    output logic [PINS-1:0] pin_buf_off_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] div_mask(input logic [2:0] code);
        case (code)
            3'h0, 3'h1: div_mask = 7'h01;
            3'h2: div_mask = 7'h03;
            3'h3: div_mask = 7'h07;
            3'h4: div_mask = 7'h0F;
            3'h5: div_mask = 7'h1F;
            3'h6: div_mask = 7'h3F;
            default: div_mask = 7'h7F;
        endcase
    endfunction : div_mask

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    typedef enum logic [1:0] {ACSR_IDLE, ACSR_CONV} acsr_state_t;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [7:1] trig_s1_q, trig_s2_q;
    logic [PINS-1:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            trig_s1_q <= '0;
            trig_s2_q <= '0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            trig_s1_q <= trig_flags_in;
            trig_s2_q <= trig_s1_q;
            pin_s1_q <= pin_level_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic on_q, on_d, auto_q, auto_d, done_q, done_d, ie_q, ie_d;
    logic [2:0] div_sel_q, div_sel_d, trig_sel_q, trig_sel_d;
    logic left_q, left_d;
    logic [4:0] mux_q, mux_d;
    logic [1:0] ref_q, ref_d;
    logic [PINS-1:0] dis_q, dis_d;
    logic [RESULT_W-1:0] res_q, res_d;
    logic lock_q, lock_d, first_q, first_d, trig_prev_q, trig_prev_d;
    logic [6:0] pre_q, pre_d;
    logic [4:0] cnt_q, cnt_d;
    acsr_state_t st_q, st_d;
    logic [IRQ_BITS-1:0] ist_q, ist_d, imask_q, imask_d;
    logic [7:0] rdata_q, rdata_d;

    logic wr_cs, wr_tc, wr_mx, wr_pd, wr_im;
    logic tick, trig_now, trig_rise, start_req, finish;
    logic [7:0] res_low, res_high, cs_byte, rd_mux;

    always_comb begin
        wr_cs = reg_wr_in && hit(reg_addr_in, OFF_CONTROL_STATUS);
        wr_tc = reg_wr_in && hit(reg_addr_in, OFF_TRIGGER_CONTROL);
        wr_mx = reg_wr_in && hit(reg_addr_in, OFF_INPUT_SELECT);
        wr_pd = reg_wr_in && hit(reg_addr_in, OFF_PIN_DISABLE);
        wr_im = reg_wr_in && hit(reg_addr_in, OFF_IRQ_MASK);
        // free run selects no flag so it never creates an edge
        trig_now = (trig_sel_q == TRIG_FREE_RUN) ? 1'b0 : trig_s2_q[trig_sel_q];
        // edge seen on the muxed signal, so a selection change can trigger
        trig_rise = trig_now && !trig_prev_q;
        tick = on_q && ((pre_q & div_mask(div_sel_q)) == div_mask(div_sel_q));
        // alignment applied at read time, so changing it acts at once
        if (left_q) begin
            res_high = res_q[9:2];
            res_low = {res_q[1:0], 6'h00};
        end else begin
            res_high = {6'h00, res_q[9:8]};
            res_low = res_q[7:0];
        end
        cs_byte = {on_q, (st_q == ACSR_CONV), auto_q, done_q, ie_q, div_sel_q};
        case (reg_addr_in)
            OFF_RESULT_LOW: rd_mux = res_low;
            OFF_RESULT_HIGH: rd_mux = res_high;
            OFF_CONTROL_STATUS: rd_mux = cs_byte;
            OFF_TRIGGER_CONTROL: rd_mux = {5'h00, trig_sel_q};
            OFF_INPUT_SELECT: rd_mux = {ref_q, left_q, mux_q};
            OFF_PIN_DISABLE: rd_mux = dis_q;
            OFF_IRQ_STATUS: rd_mux = {{(8-IRQ_BITS){1'b0}}, ist_q};
            OFF_IRQ_MASK: rd_mux = {{(8-IRQ_BITS){1'b0}}, imask_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        on_d = on_q;
        auto_d = auto_q;
        ie_d = ie_q;
        div_sel_d = div_sel_q;
        trig_sel_d = trig_sel_q;
        left_d = left_q;
        mux_d = mux_q;
        ref_d = ref_q;
        dis_d = dis_q;
        imask_d = imask_q;
        lock_d = lock_q;
        res_d = res_q;
        first_d = first_q;
        st_d = st_q;
        cnt_d = cnt_q;
        pre_d = on_q ? pre_q + 7'h01 : 7'h00;
        trig_prev_d = trig_now;
        rdata_d = reg_rd_in ? rd_mux : 8'h00;
        done_d = done_q;
        ist_d = ist_q;
        finish = 1'b0;
        start_req = 1'b0;

        if (wr_cs) begin
            on_d = reg_wdata_in[BIT_CONVERTER_ON];
            auto_d = reg_wdata_in[BIT_AUTO_TRIG_EN];
            ie_d = reg_wdata_in[BIT_DONE_IRQ_EN];
            div_sel_d = reg_wdata_in[2:0];
            start_req = reg_wdata_in[BIT_START_BUSY]; // writing zero ignored
        end
        if (wr_tc) trig_sel_d = reg_wdata_in[2:0] & TRIG_CTRL_WMASK[2:0];
        if (wr_mx) begin
            ref_d = reg_wdata_in[7:6];
            left_d = reg_wdata_in[BIT_LEFT_ALIGN];
            mux_d = reg_wdata_in[4:0];
        end
        if (wr_pd) dis_d = reg_wdata_in;
        if (wr_im) imask_d = reg_wdata_in[IRQ_BITS-1:0];
        if (auto_q && trig_rise) start_req = 1'b1;
        if (!on_q && wr_cs && reg_wdata_in[BIT_CONVERTER_ON]) first_d = 1'b1;

        // result read lock
        if (reg_rd_in && hit(reg_addr_in, OFF_RESULT_LOW)) lock_d = 1'b1;
        if (reg_rd_in && hit(reg_addr_in, OFF_RESULT_HIGH)) lock_d = 1'b0;

        case (st_q)
            ACSR_IDLE: begin
                if (start_req && on_d) begin
                    st_d = ACSR_CONV;
                    cnt_d = (first_q || first_d) ? FIRST_CONV_CYCLES : NORMAL_CONV_CYCLES;
                    first_d = 1'b0;
                end
            end
            ACSR_CONV: begin
                if (tick) begin
                    if (cnt_q == 5'd1) begin
                        finish = 1'b1;
                        // free running re-arms itself on completion
                        st_d = (auto_q && trig_sel_q == TRIG_FREE_RUN) ? ACSR_CONV : ACSR_IDLE;
                        cnt_d = NORMAL_CONV_CYCLES;
                    end else begin
                        cnt_d = cnt_q - 5'd1;
                    end
                end
            end
            default: st_d = ACSR_IDLE;
        endcase
        if (!on_d) begin
            st_d = ACSR_IDLE;
            first_d = 1'b0;
        end

        // a clear through write or vector loses to a new completion
        if (wr_cs && reg_wdata_in[BIT_DONE_FLAG]) done_d = 1'b0;
        if (vector_taken_in) done_d = 1'b0;
        if (reg_rd_in && hit(reg_addr_in, OFF_IRQ_STATUS)) ist_d = '0;
        if (finish) begin
            if (!lock_d) begin
                res_d = sample_in; // result written in the same cycle the flag rises
                done_d = 1'b1;
                ist_d[0] = 1'b1;
            end else begin
                ist_d[1] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // software-visible settings, all cleared by reset
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            on_q <= 1'b0;
            auto_q <= 1'b0;
            ie_q <= 1'b0;
            div_sel_q <= 3'h0;
            trig_sel_q <= 3'h0;
            left_q <= 1'b0;
            mux_q <= 5'h00;
            ref_q <= 2'h0;
            dis_q <= RESET_BYTE;
            imask_q <= '0;
        end else begin
            on_q <= on_d;
            auto_q <= auto_d;
            ie_q <= ie_d;
            div_sel_q <= div_sel_d;
            trig_sel_q <= trig_sel_d;
            left_q <= left_d;
            mux_q <= mux_d;
            ref_q <= ref_d;
            dis_q <= dis_d;
            imask_q <= imask_d;
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    // prescaler restarts from zero at each enable, so tick phase is free
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            first_q <= 1'b0;
            trig_prev_q <= 1'b0;
            pre_q <= 7'h00;
            cnt_q <= 5'h00;
            st_q <= ACSR_IDLE;
        end else begin
            first_q <= first_d;
            trig_prev_q <= trig_prev_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // result and lock registers
    // ------------------------------------------------------------
    // raw sample kept; alignment is only a view at read time
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            res_q <= '0;
            lock_q <= 1'b0;
        end else begin
            res_q <= res_d;
            lock_q <= lock_d;
        end
    end

    // ------------------------------------------------------------
    // flag and readback registers
    // ------------------------------------------------------------
    // read data stands one cycle and is zero otherwise
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            done_q <= 1'b0;
            ist_q <= '0;
            rdata_q <= RESET_BYTE;
        end else begin
            done_q <= done_d;
            ist_q <= ist_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        reg_rdata_out = rdata_q;
        conv_irq_req_out = done_q && ie_q && global_irq_en_in;
        irq_out = |(ist_q & imask_q);
        core_power_out = on_q;
        core_clk_en_out = tick && (st_q == ACSR_CONV);
        input_select_out = mux_q;
        ref_select_out = ref_q;
        pin_buf_off_out = dis_q;
        pin_read_out = pin_s2_q & ~dis_q;
    end
endmodule : acsr_ctrl

// File: acsr_ctrl_checker.sv
/* acsr_ctrl_checker: port-level assertions for acsr_ctrl.
   assumes: bound to acsr_ctrl, single clock, sync active-low reset. */
`timescale 1ns/10ps
module acsr_ctrl_checker
    import acsr_pkg::*;
#(
    parameter int RESULT_W = 10,
    parameter int PINS = 8
) (
    // clock, reset and register port
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // interrupt, converter and pins
    input wire logic global_irq_en_in,
    input wire logic vector_taken_in,
    input wire logic conv_irq_req_out,
    input wire logic core_power_out,
    input wire logic core_clk_en_out,
    input wire logic [PINS-1:0] pin_read_out,
    input wire logic [PINS-1:0] pin_buf_off_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // clear is only checked away from a tick, where set would win
    sequence done_clr;
        reg_wr_in && reg_addr_in == OFF_CONTROL_STATUS && reg_wdata_in[4] && !core_clk_en_out;
    endsequence
    sequence conv_off;
        reg_wr_in && reg_addr_in == OFF_CONTROL_STATUS && !reg_wdata_in[7];
    endsequence
    sequence trig_read;
        reg_rd_in && reg_addr_in == OFF_TRIGGER_CONTROL;
    endsequence
    irq_gate_a: assert property (conv_irq_req_out |-> global_irq_en_in)
        else $error("request without global enable");
    vec_clear_a: assert property (vector_taken_in && !core_clk_en_out |=> !conv_irq_req_out)
        else $error("vector did not clear done");
    done_w1c_a: assert property (done_clr |=> !conv_irq_req_out)
        else $error("write one did not clear done");
    tick_gap_a: assert property (core_clk_en_out |=> !core_clk_en_out)
        else $error("ticks closer than two clocks");
    tick_power_a: assert property (core_clk_en_out |-> core_power_out)
        else $error("tick while converter off");
    abort_off_a: assert property (conv_off |-> ##2 (!core_power_out && !core_clk_en_out)[*4])
        else $error("converter still running after off");
    trig_rsvd_a: assert property (trig_read |=> reg_rdata_out[7:3] == 5'h00)
        else $error("reserved trigger bits not zero");
    pin_block_a: assert property ((pin_read_out & pin_buf_off_out) == '0)
        else $error("disabled pin reads one");
    pin_dis_wr_a: assert property (reg_wr_in && reg_addr_in == OFF_PIN_DISABLE
        |=> pin_buf_off_out == $past(reg_wdata_in))
        else $error("pin disable not applied");
endmodule : acsr_ctrl_checker

bind acsr_ctrl acsr_ctrl_checker #(.RESULT_W(RESULT_W), .PINS(PINS)) acsr_ctrl_checker_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .global_irq_en_in(global_irq_en_in),
    .vector_taken_in(vector_taken_in), .conv_irq_req_out(conv_irq_req_out),
    .core_power_out(core_power_out), .core_clk_en_out(core_clk_en_out),
    .pin_read_out(pin_read_out), .pin_buf_off_out(pin_buf_off_out));

// File: test_acsr_ctrl.sv
/* test_acsr_ctrl: self-checking bench for acsr_ctrl.
   assumes: 10 MHz clock; reads queued, checked the cycle after the strobe. */
`timescale 1ns/10ps
module test_acsr_ctrl;
    import acsr_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pin_level_in = 8'h00;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, global_irq_en_in = 1'b0, vector_taken_in = 1'b0;
    logic [9:0] sample_in = 10'h000, s;
    logic [7:1] trig_flags_in = 7'h00;
    logic [7:0] reg_rdata_out, pin_read_out, pin_buf_off_out, d;
    logic conv_irq_req_out, irq_out, rd_d = 1'b0;
    logic [7:0] exp_q[$], msk_q[$];
    int n_errors = 0, check_count = 0, n, k;
    always #50 mclk_in = ~mclk_in;
    acsr_ctrl acsr_ctrl_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .global_irq_en_in(global_irq_en_in), .vector_taken_in(vector_taken_in),
        .conv_irq_req_out(conv_irq_req_out), .irq_out(irq_out), .sample_in(sample_in),
        .core_power_out(), .core_clk_en_out(), .input_select_out(), .ref_select_out(),
        .trig_flags_in(trig_flags_in), .pin_level_in(pin_level_in),
        .pin_read_out(pin_read_out), .pin_buf_off_out(pin_buf_off_out));
    // --------------------------------
    // checking and bus tasks
    // --------------------------------
    task test_done;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // edge first, then drive: each strobe stands exactly one cycle
    task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= v;
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, 1'b0, a, v);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, 1'b1, a, 8'($urandom));
    endtask : rd
    task idle(input int c);
        repeat (c) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : idle
    // tick phase is free, so allow one tick plus sync slack either way
    task wait_req(input int t, input int dv);
        n = 0;
        while (conv_irq_req_out !== 1'b1 && n < 3000) begin
            idle(1);
            #1;
            n++;
        end
        chk("conv_time", 8'h01, 8'(n >= t * dv - dv - 2 && n <= t * dv + dv + 6));
    endtask : wait_req
    always @(posedge mclk_in) begin
        rd_d <= reg_rd_in;
        if (rd_d) chk("rdata", exp_q.pop_front(), reg_rdata_out & msk_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_errors++;
        test_done();
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        void'($urandom(32'h69FF));
        repeat (16) @(posedge mclk_in);
        resetn_in <= 1'b1;
        rd(OFF_RESULT_LOW, 8'h00, 8'hFF);
        rd(OFF_RESULT_HIGH, 8'h00, 8'hFF);
        rd(OFF_CONTROL_STATUS, 8'h00, 8'hFF);
        wr(OFF_TRIGGER_CONTROL, 8'h7F);
        rd(OFF_TRIGGER_CONTROL, 8'h07, 8'hFF);
        rd(8'h90, 8'h00, 8'hFF);
        d = 8'($urandom);
        wr(OFF_PIN_DISABLE, d);
        pin_level_in <= 8'($urandom);
        idle(4);
        #1;
        chk("pin_read", pin_level_in & ~d, pin_read_out);
        s = 10'($urandom);
        wr(OFF_IRQ_MASK, 8'h01);
        sample_in <= s;
        global_irq_en_in <= 1'b1;
        wr(OFF_CONTROL_STATUS, 8'hC8);
        wait_req(25, 2);
        chk("irq", 8'h01, 8'(irq_out));
        rd(OFF_CONTROL_STATUS, 8'h98, 8'hFF);
        rd(OFF_RESULT_LOW, s[7:0], 8'hFF);
        rd(OFF_RESULT_HIGH, {6'h00, s[9:8]}, 8'hFF);
        wr(OFF_IRQ_MASK, 8'h00);
        global_irq_en_in <= 1'b0;
        idle(1);
        #1;
        chk("irq_masked", 8'h00, 8'(irq_out));
        chk("req_gated", 8'h00, 8'(conv_irq_req_out));
        rd(OFF_IRQ_STATUS, 8'h01, 8'hFF);
        wr(OFF_IRQ_MASK, 8'h01);
        global_irq_en_in <= 1'b1;
        wr(OFF_CONTROL_STATUS, 8'h98);
        idle(1);
        #1;
        chk("irq_read_clear", 8'h00, 8'(irq_out));
        chk("done_w1c", 8'h00, 8'(conv_irq_req_out));
        s = 10'($urandom);
        wr(OFF_INPUT_SELECT, 8'h20);
        sample_in <= s;
        wr(OFF_CONTROL_STATUS, 8'hCB);
        wait_req(13, 8);
        idle(1);
        vector_taken_in <= 1'b1;
        idle(1);
        vector_taken_in <= 1'b0;
        idle(1);
        #1;
        chk("vector_clear", 8'h00, 8'(conv_irq_req_out));
        rd(OFF_RESULT_HIGH, s[9:2], 8'hFF);
        rd(OFF_RESULT_LOW, {s[1:0], 6'h00}, 8'hFF);
        sample_in <= ~s;
        wr(OFF_CONTROL_STATUS, 8'hCB);
        idle(13 * 8 + 24);
        rd(OFF_IRQ_STATUS, 8'h02, 8'h02);
        rd(OFF_CONTROL_STATUS, 8'h00, 8'h50);
        rd(OFF_RESULT_HIGH, s[9:2], 8'hFF);
        wr(OFF_INPUT_SELECT, 8'h00);
        for (k = 1; k < 8; k++) begin
            wr(OFF_TRIGGER_CONTROL, 8'(k));
            wr(OFF_CONTROL_STATUS, 8'hB8);
            trig_flags_in <= 7'h7F ^ (7'h01 << (k - 1));
            idle(12);
            #1;
            chk("unselected_flag", 8'h00, 8'(conv_irq_req_out));
            idle(1);
            trig_flags_in <= 7'h7F;
            wait_req(13, 2);
            idle(1);
            trig_flags_in <= 7'h00;
        end
        wr(OFF_TRIGGER_CONTROL, 8'h01);
        trig_flags_in <= 7'h10;
        wr(OFF_CONTROL_STATUS, 8'hB8);
        idle(8);
        wr(OFF_TRIGGER_CONTROL, 8'h05);
        wait_req(13, 2);
        wr(OFF_TRIGGER_CONTROL, 8'h00);
        idle(8);
        rd(OFF_CONTROL_STATUS, 8'h00, 8'h40);
        wr(OFF_CONTROL_STATUS, 8'hDF);
        idle(20);
        wr(OFF_CONTROL_STATUS, 8'h8F);
        rd(OFF_CONTROL_STATUS, 8'h40, 8'h40);
        wr(OFF_CONTROL_STATUS, 8'h00);
        idle(3);
        rd(OFF_CONTROL_STATUS, 8'h00, 8'hFF);
        idle(13 * 128 + 40);
        #1;
        chk("aborted", 8'h00, 8'(conv_irq_req_out));
        idle(3);
        test_done();
    end
endmodule : test_acsr_ctrl
